// ---- core/crs_defines.vh ----
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// data-space addresses of the core registers
`define CRS_ADDR_PTR0 8'h80
`define CRS_ADDR_PTR1 8'h81
`define CRS_ADDR_SHORT0 8'h82
`define CRS_ADDR_SHORT1 8'h83
`define CRS_ADDR_ACC 8'hFF
// reset vector location in program space (low byte, high byte follows)
`define CRS_RST_VEC_LO 12'hFFE
`define CRS_RST_VEC_HI 12'hFFF
// clock divide for the machine cycle
`define CRS_MC_DIV 13
// modes
`define CRS_MODE_NORM 2'h0
`define CRS_MODE_INT 2'h1
`define CRS_MODE_NMI 2'h2
// program counter operations
`define CRS_PC_HOLD 3'h0
`define CRS_PC_INC 3'h1
`define CRS_PC_REL 3'h2
`define CRS_PC_JUMP 3'h3
`define CRS_PC_CALL 3'h4
`define CRS_PC_INTR 3'h5
`define CRS_PC_RET 3'h6
`define CRS_PC_INTERRUPT_RETURN 3'h7
// sequencer states
`define CRS_ST_VLO 2'h0
`define CRS_ST_VHI 2'h1
`define CRS_ST_RUN 2'h2
`endif

// ---- core/crs_mc_div.v ----
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module crs_mc_div #(
    parameter DIV = `CRS_MC_DIV
) (
    input wire mclk_i,
    input wire rst_i,
    output reg mc_en_o
);
    reg [3:0] cnt_ff;
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
            mc_en_o <= 1'b0;
        end else begin
            mc_en_o <= (cnt_ff == DIV - 1);
            if (cnt_ff == DIV - 1) begin
                cnt_ff <= 4'h0;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- core/crs_stack.v ----
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module crs_stack #(
    parameter DEPTH = 6,
    parameter AW = 12
) (
    input wire mclk_i,
    input wire rst_i,
    input wire push_i,
    input wire pop_i,
    input wire [AW-1:0] push_val_i,
    output wire [AW-1:0] top_o,
    output reg empty_o,
    output reg full_o
);
    reg [AW-1:0] lvl_ff [0:DEPTH-1];
    reg [3:0] cnt_ff;
    assign top_o = lvl_ff[0];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : lv
            always @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    lvl_ff[g] <= {AW{1'b0}};
                end else if (push_i) begin
                    if (g == 0) begin
                        lvl_ff[g] <= push_val_i;
                    end else begin
                        lvl_ff[g] <= lvl_ff[g-1];
                    end
                end else if (pop_i) begin
                    if (g == DEPTH - 1) begin
                        lvl_ff[g] <= {AW{1'b0}};
                    end else begin
                        lvl_ff[g] <= lvl_ff[g+1];
                    end
                end
            end
        end
    endgenerate
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
        end else if (push_i && cnt_ff != DEPTH) begin
            cnt_ff <= cnt_ff + 4'h1;
        end else if (pop_i && !push_i && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    always @* begin
        empty_o = (cnt_ff == 4'h0);
        full_o = (cnt_ff == DEPTH);
    end
endmodule
`default_nettype wire

// ---- core/crs_core_regs.v ----
// Functional notes
// - 8-bit accumulator, also data address FFh
// - two pointer registers at 80h, 81h
// - two short-direct registers at 82h, 83h
// - 12-bit program counter, 4096 bytes
// - program counter increments after fetch
// - relative branch adds signed offset to pc
// - pc loads jump, vector, reset, pop targets
// - three carry/zero pairs, one per mode
// - interrupt entry switches pair, return restores
// - switching keeps pairs; only active pair reachable
// - carry from arithmetic, bit test, rotate
// - zero set when result is zero
// - reset starts in nmi mode
// - six 12-bit levels, push shifts down
// - return pops level one into pc
// - overflow keeps newest six, oldest lost
// - return on empty stack keeps pc
// - only program counter is pushed
// - machine cycle is clock divided by 13
// - instructions take 2, 4 or 5 cycles
// - reset empties stack, loads reset vector
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module crs_core_regs #(
    parameter PCW = 12
) (
    input wire mclk_i,
    input wire rst_i,
    // program memory read port for the reset vector fetch
    output reg [PCW-1:0] prog_addr_o,
    input wire [7:0] prog_data_i,
    // sequencer step request, taken on a machine cycle
    input wire step_i,
    input wire [2:0] pc_op_i,
    input wire [PCW-1:0] pc_target_i,
    input wire [7:0] rel_offset_i,
    // nmi entry when high with pc_op intr, else normal interrupt
    input wire intr_nmi_i,
    // data-space access
    input wire data_we_i,
    input wire [7:0] data_addr_i,
    input wire [7:0] data_wdata_i,
    output reg [7:0] data_rdata_o,
    output reg data_hit_o,
    // implicit accumulator and flag update from the alu
    input wire acc_we_i,
    input wire [7:0] acc_wdata_i,
    input wire carry_we_i,
    input wire carry_i,
    input wire zero_we_i,
    input wire zero_i,
    output reg [7:0] acc_o,
    output reg [7:0] ptr0_o,
    output reg [7:0] ptr1_o,
    output reg [7:0] short0_o,
    output reg [7:0] short1_o,
    output reg [PCW-1:0] pc_o,
    output reg carry_o,
    output reg zero_o,
    output reg [1:0] mode_o,
    output reg mc_en_o,
    output reg running_o,
    output reg stack_empty_o,
    output reg stack_full_o
);
    reg [7:0] acc_ff;
    reg [7:0] ptr0_ff;
    reg [7:0] ptr1_ff;
    reg [7:0] short0_ff;
    reg [7:0] short1_ff;
    reg [PCW-1:0] pc_ff;
    reg [PCW-1:0] nxt_pc;
    reg [7:0] nxt_rdata;
    reg nxt_hit;
    reg [2:0] carry_ff;
    reg [2:0] zero_ff;
    reg [1:0] mode_ff;
    reg [1:0] prev_mode_ff;
    reg [1:0] st_ff;
    reg [7:0] vec_lo_ff;
    wire mc_en;
    wire [PCW-1:0] stk_top;
    wire stk_empty;
    wire stk_full;
    wire run_step;
    wire do_push;
    wire do_pop;
    wire [PCW-1:0] rel_sum;

    // machine cycle divider
    crs_mc_div #(
        .DIV(`CRS_MC_DIV)
    ) u_div (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .mc_en_o(mc_en)
    );

    assign run_step = mc_en && step_i && (st_ff == `CRS_ST_RUN);
    assign do_push = run_step && (pc_op_i == `CRS_PC_CALL || pc_op_i == `CRS_PC_INTR);
    assign do_pop = run_step && (pc_op_i == `CRS_PC_RET || pc_op_i == `CRS_PC_INTERRUPT_RETURN);

    crs_stack #(
        .DEPTH(6),
        .AW(PCW)
    ) u_stk (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .push_i(do_push),
        .pop_i(do_pop),
        .push_val_i(pc_ff),
        .top_o(stk_top),
        .empty_o(stk_empty),
        .full_o(stk_full)
    );

    assign rel_sum = pc_ff + {{(PCW-8){rel_offset_i[7]}}, rel_offset_i};

    always @* begin
        nxt_pc = pc_ff;
        case (pc_op_i)
            `CRS_PC_INC: nxt_pc = pc_ff + {{(PCW-1){1'b0}}, 1'b1};
            `CRS_PC_REL: nxt_pc = rel_sum;
            `CRS_PC_JUMP: nxt_pc = pc_target_i;
            `CRS_PC_CALL: nxt_pc = pc_target_i;
            `CRS_PC_INTR: nxt_pc = pc_target_i;
            // pop or fall through when empty
            `CRS_PC_RET: nxt_pc = stk_empty ? pc_ff : stk_top;
            `CRS_PC_INTERRUPT_RETURN: nxt_pc = stk_empty ? pc_ff : stk_top;
            default: nxt_pc = pc_ff;
        endcase
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= `CRS_ST_VLO;
            vec_lo_ff <= 8'h00;
            pc_ff <= {PCW{1'b0}};
        end else if (mc_en) begin
            case (st_ff)
                `CRS_ST_VLO: begin
                    vec_lo_ff <= prog_data_i;
                    st_ff <= `CRS_ST_VHI;
                end
                `CRS_ST_VHI: begin
                    pc_ff <= {prog_data_i[PCW-9:0], vec_lo_ff};
                    st_ff <= `CRS_ST_RUN;
                end
                `CRS_ST_RUN: begin
                    if (step_i) begin
                        pc_ff <= nxt_pc;
                    end
                end
                default: st_ff <= `CRS_ST_VLO;
            endcase
        end
    end

    always @* begin
        case (st_ff)
            `CRS_ST_VLO: prog_addr_o = `CRS_RST_VEC_LO;
            `CRS_ST_VHI: prog_addr_o = `CRS_RST_VEC_HI;
            default: prog_addr_o = pc_ff;
        endcase
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_ff <= `CRS_MODE_NMI;
            prev_mode_ff <= `CRS_MODE_NORM;
        end else if (run_step) begin
            if (pc_op_i == `CRS_PC_INTR) begin
                prev_mode_ff <= mode_ff;
                mode_ff <= intr_nmi_i ? `CRS_MODE_NMI : `CRS_MODE_INT;
            end else if (pc_op_i == `CRS_PC_INTERRUPT_RETURN) begin
                mode_ff <= prev_mode_ff;
                prev_mode_ff <= `CRS_MODE_NORM;
            end
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_ff <= 8'h00;
        end else if (acc_we_i) begin
            acc_ff <= acc_wdata_i;
        end else if (data_we_i && data_addr_i == `CRS_ADDR_ACC) begin
            acc_ff <= data_wdata_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr0_ff <= 8'h00;
        end else if (data_we_i && data_addr_i == `CRS_ADDR_PTR0) begin
            ptr0_ff <= data_wdata_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr1_ff <= 8'h00;
        end else if (data_we_i && data_addr_i == `CRS_ADDR_PTR1) begin
            ptr1_ff <= data_wdata_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            short0_ff <= 8'h00;
        end else if (data_we_i && data_addr_i == `CRS_ADDR_SHORT0) begin
            short0_ff <= data_wdata_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            short1_ff <= 8'h00;
        end else if (data_we_i && data_addr_i == `CRS_ADDR_SHORT1) begin
            short1_ff <= data_wdata_i;
        end
    end

    always @* begin
        nxt_hit = 1'b1;
        case (data_addr_i)
            `CRS_ADDR_ACC: nxt_rdata = acc_ff;
            `CRS_ADDR_PTR0: nxt_rdata = ptr0_ff;
            `CRS_ADDR_PTR1: nxt_rdata = ptr1_ff;
            `CRS_ADDR_SHORT0: nxt_rdata = short0_ff;
            `CRS_ADDR_SHORT1: nxt_rdata = short1_ff;
            default: begin
                nxt_rdata = 8'h00;
                nxt_hit = 1'b0;
            end
        endcase
    end

    genvar m;
    generate
        for (m = 0; m < 3; m = m + 1) begin : fl
            always @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    carry_ff[m] <= 1'b0;
                    zero_ff[m] <= 1'b0;
                end else if (mode_ff == m) begin
                    if (carry_we_i) begin
                        carry_ff[m] <= carry_i;
                    end
                    if (zero_we_i) begin
                        zero_ff[m] <= zero_i;
                    end
                end
            end
        end
    endgenerate

    // registered data-space read port
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            data_rdata_o <= 8'h00;
            data_hit_o <= 1'b0;
        end else begin
            data_rdata_o <= nxt_rdata;
            data_hit_o <= nxt_hit;
        end
    end

    // registered copies of the data-space registers
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_o <= 8'h00;
            ptr0_o <= 8'h00;
            ptr1_o <= 8'h00;
            short0_o <= 8'h00;
            short1_o <= 8'h00;
        end else begin
            acc_o <= acc_ff;
            ptr0_o <= ptr0_ff;
            ptr1_o <= ptr1_ff;
            short0_o <= short0_ff;
            short1_o <= short1_ff;
        end
    end

    // pc, mode and the flags of the active pair
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_o <= {PCW{1'b0}};
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            mode_o <= `CRS_MODE_NMI;
        end else begin
            pc_o <= pc_ff;
            carry_o <= carry_ff[mode_ff];
            zero_o <= zero_ff[mode_ff];
            mode_o <= mode_ff;
        end
    end

    // sequencer status
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mc_en_o <= 1'b0;
            running_o <= 1'b0;
            stack_empty_o <= 1'b1;
            stack_full_o <= 1'b0;
        end else begin
            mc_en_o <= mc_en;
            running_o <= (st_ff == `CRS_ST_RUN);
            stack_empty_o <= stk_empty;
            stack_full_o <= stk_full;
        end
    end
endmodule
`default_nettype wire

// ---- tb/crs_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module crs_prog_model #(
    parameter logic [7:0] VEC_LO = 8'h34,
    parameter logic [7:0] VEC_HI = 8'hA2
) (
    input wire logic [11:0] prog_addr_i,
    output logic [7:0] prog_data_o
);
    always_comb begin
        if (prog_addr_i == `CRS_RST_VEC_LO) begin
            prog_data_o = VEC_LO;
        end else if (prog_addr_i == `CRS_RST_VEC_HI) begin
            prog_data_o = VEC_HI;
        end else begin
            prog_data_o = ~prog_addr_i[7:0];
        end
    end
endmodule
`default_nettype wire

// ---- tb/crs_core_regs_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module crs_core_regs_sva #(
    parameter PCW = 12
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] data_addr_i,
    input wire logic [7:0] data_rdata_o,
    input wire logic data_hit_o,
    input wire logic [PCW-1:0] pc_o,
    input wire logic [1:0] mode_o,
    input wire logic mc_en_o,
    input wire logic running_o,
    input wire logic stack_empty_o,
    input wire logic stack_full_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence mc_gap;
        (!mc_en_o) [*8] ##1 (!mc_en_o) [*4];
    endsequence
    sequence mc_recent;
        $past(mc_en_o) || $past(mc_en_o, 2) || $past(mc_en_o, 3);
    endsequence
    chk_mc_period: assert property (mc_en_o |=> mc_gap ##1 mc_en_o)
        else $error("machine cycle spacing wrong");
    chk_pc_on_cycle: assert property ($changed(pc_o) |-> mc_recent)
        else $error("pc changed off a machine cycle");
    chk_mode_on_cycle: assert property ($changed(mode_o) |-> mc_recent)
        else $error("mode changed off a machine cycle");
    chk_reset_mode: assert property ($rose(running_o) |-> mode_o == `CRS_MODE_NMI)
        else $error("start not in nmi mode");
    chk_running_kept: assert property (running_o |=> running_o)
        else $error("running dropped");
    chk_unmapped_zero: assert property (!data_hit_o |-> data_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_hit_decode: assert property (!$past(rst_i) |-> data_hit_o ==
        ($past(data_addr_i[7:2]) == 6'h20 || $past(data_addr_i) == 8'hFF))
        else $error("address decode wrong");
    chk_stack_excl: assert property (!(stack_full_o && stack_empty_o))
        else $error("stack full and empty");
endmodule
bind crs_core_regs crs_core_regs_sva #(.PCW(PCW)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .data_addr_i(data_addr_i),
    .data_rdata_o(data_rdata_o), .data_hit_o(data_hit_o), .pc_o(pc_o),
    .mode_o(mode_o), .mc_en_o(mc_en_o), .running_o(running_o),
    .stack_empty_o(stack_empty_o), .stack_full_o(stack_full_o));
`default_nettype wire

// ---- tb/test_cpu_register_stack_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "crs_defines.vh"
module test_cpu_register_stack_flags;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic step_i = 1'b0;
    logic [2:0] pc_op_i = 3'h0;
    logic [11:0] pc_target_i = 12'h000;
    logic [7:0] rel_offset_i = 8'h00;
    logic intr_nmi_i = 1'b0;
    logic data_we_i = 1'b0;
    logic [7:0] data_addr_i = 8'h00;
    logic [7:0] data_wdata_i = 8'h00;
    logic acc_we_i = 1'b0;
    logic [7:0] acc_wdata_i = 8'h00;
    logic carry_we_i = 1'b0;
    logic carry_i = 1'b0;
    logic zero_we_i = 1'b0;
    logic zero_i = 1'b0;
    wire [11:0] prog_addr_o, pc_o;
    wire [7:0] prog_data_i, data_rdata_o, acc_o, ptr0_o, ptr1_o, short0_o, short1_o;
    wire data_hit_o, carry_o, zero_o, mc_en_o, running_o, stack_empty_o, stack_full_o;
    wire [1:0] mode_o;
    logic [7:0] addrs [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
    int err_total = 0;
    int check_count = 0;
    int n;
    always #50 mclk_i = ~mclk_i;
    crs_prog_model prog (.prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i));
    crs_core_regs dut (.mclk_i(mclk_i), .rst_i(rst_i), .prog_addr_o(prog_addr_o),
        .prog_data_i(prog_data_i), .step_i(step_i), .pc_op_i(pc_op_i),
        .pc_target_i(pc_target_i), .rel_offset_i(rel_offset_i), .intr_nmi_i(intr_nmi_i),
        .data_we_i(data_we_i), .data_addr_i(data_addr_i), .data_wdata_i(data_wdata_i),
        .data_rdata_o(data_rdata_o), .data_hit_o(data_hit_o), .acc_we_i(acc_we_i),
        .acc_wdata_i(acc_wdata_i), .carry_we_i(carry_we_i), .carry_i(carry_i),
        .zero_we_i(zero_we_i), .zero_i(zero_i), .acc_o(acc_o), .ptr0_o(ptr0_o),
        .ptr1_o(ptr1_o), .short0_o(short0_o), .short1_o(short1_o), .pc_o(pc_o),
        .carry_o(carry_o), .zero_o(zero_o), .mode_o(mode_o), .mc_en_o(mc_en_o),
        .running_o(running_o), .stack_empty_o(stack_empty_o), .stack_full_o(stack_full_o));
    task automatic compare(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        data_we_i = 1'b1;
        data_addr_i = a;
        data_wdata_i = d;
        @(negedge mclk_i);
        data_we_i = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(negedge mclk_i);
        data_addr_i = a;
        @(negedge mclk_i);
        compare(nm, data_rdata_o, exp);
    endtask
    task automatic wait_mc;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (mc_en_o !== 1'b1 && n < 40);
    endtask
    // request is raised just after a pulse so the next internal enable takes it
    task automatic step(input logic [2:0] op, input logic [11:0] tgt, input logic [7:0] off,
                        input logic nmi);
        wait_mc();
        step_i = 1'b1;
        pc_op_i = op;
        pc_target_i = tgt;
        rel_offset_i = off;
        intr_nmi_i = nmi;
        wait_mc();
        step_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic flags(input logic c, input logic z);
        @(negedge mclk_i);
        carry_we_i = 1'b1;
        zero_we_i = 1'b1;
        carry_i = c;
        zero_i = z;
        @(negedge mclk_i);
        carry_we_i = 1'b0;
        zero_we_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic ctx(input logic [1:0] m, input logic c, input logic z);
        compare("mode", mode_o, m);
        compare("carry", carry_o, c);
        compare("zero", zero_o, z);
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        conclude();
    end
    initial begin
        repeat (12) @(negedge mclk_i);
        compare("mode", mode_o, `CRS_MODE_NMI);
        compare("empty", stack_empty_o, 1'b1);
        rst_i = 1'b0;
        n = 0;
        while (running_o !== 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        compare("pc", pc_o, 12'h234);
        for (int i = 0; i < 5; i++) begin
            wr(addrs[i], 8'h81 + 8'(i) * 8'h11);
        end
        for (int i = 0; i < 5; i++) begin
            rd(addrs[i], 8'h81 + 8'(i) * 8'h11, "data");
        end
        compare("ptr0", ptr0_o, 8'h81);
        compare("short0", short0_o, 8'hA3);
        compare("ptr1", ptr1_o, 8'h92);
        compare("short1", short1_o, 8'hB4);
        compare("acc", acc_o, 8'hC5);
        rd(8'h84, 8'h00, "unmapped");
        compare("hit", data_hit_o, 1'b0);
        acc_we_i = 1'b1;
        acc_wdata_i = 8'h5A;
        wr(8'hFF, 8'hC3);
        acc_we_i = 1'b0;
        rd(8'hFF, 8'h5A, "acc");
        flags(1'b1, 1'b0);
        ctx(`CRS_MODE_NMI, 1'b1, 1'b0);
        step(`CRS_PC_INTR, 12'h3F0, 8'h00, 1'b0);
        ctx(`CRS_MODE_INT, 1'b0, 1'b0);
        compare("pc", pc_o, 12'h3F0);
        flags(1'b0, 1'b1);
        ctx(`CRS_MODE_INT, 1'b0, 1'b1);
        step(`CRS_PC_INTERRUPT_RETURN, 12'h000, 8'h00, 1'b0);
        ctx(`CRS_MODE_NMI, 1'b1, 1'b0);
        compare("pc", pc_o, 12'h234);
        step(`CRS_PC_INTERRUPT_RETURN, 12'h000, 8'h00, 1'b0);
        ctx(`CRS_MODE_NORM, 1'b0, 1'b0);
        compare("pc", pc_o, 12'h234);
        step(`CRS_PC_INTR, 12'h3FC, 8'h00, 1'b1);
        ctx(`CRS_MODE_NMI, 1'b1, 1'b0);
        step(`CRS_PC_INTERRUPT_RETURN, 12'h000, 8'h00, 1'b0);
        compare("mode", mode_o, `CRS_MODE_NORM);
        step(`CRS_PC_INC, 12'h000, 8'h00, 1'b0);
        compare("pc", pc_o, 12'h235);
        step(`CRS_PC_REL, 12'h000, 8'hFE, 1'b0);
        compare("pc", pc_o, 12'h233);
        step(`CRS_PC_JUMP, 12'hFFF, 8'h00, 1'b0);
        compare("pc", pc_o, 12'hFFF);
        step(`CRS_PC_INC, 12'h000, 8'h00, 1'b0);
        compare("pc", pc_o, 12'h000);
        step(`CRS_PC_HOLD, 12'h555, 8'h00, 1'b0);
        compare("pc", pc_o, 12'h000);
        for (int i = 1; i < 8; i++) begin
            step(`CRS_PC_CALL, 12'h100 + 12'(i), 8'h00, 1'b0);
            compare("pc", pc_o, 12'h100 + 12'(i));
        end
        compare("full", stack_full_o, 1'b1);
        rd(8'hFF, 8'h5A, "acc");
        for (int i = 6; i > 0; i--) begin
            step(`CRS_PC_RET, 12'h000, 8'h00, 1'b0);
            compare("pc", pc_o, 12'h100 + 12'(i));
        end
        compare("empty", stack_empty_o, 1'b1);
        step(`CRS_PC_RET, 12'h000, 8'h00, 1'b0);
        compare("pc", pc_o, 12'h101);
        compare("empty", stack_empty_o, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
